// ### rsg_defines.vh
// rsg_defines.vh: constants for the table-based sine generator
// assumes inclusion by rsg_sine_gen.v, the checker and the bench; definitions only
`ifndef RSG_DEFINES_VH
`define RSG_DEFINES_VH

`define RSG_MCLK_HZ       7680000
`define RSG_CPU_DIV       4
`define RSG_CPU_DIV_W     2
`define RSG_N_W           12
`define RSG_N_MIN         12'h003
`define RSG_N_MAX         12'hBB8
`define RSG_N_RST         12'h003
`define RSG_ADDR_W        7
`define RSG_ADDR_LAST     7'h7F
`define RSG_ADDR_ZERO     7'h00
`define RSG_DATA_W        8
`define RSG_ROM_DEPTH     256
`define RSG_TAB_ENTRIES   128
`define RSG_MID           8'h80
`define RSG_AMPL          127
`define RSG_TWO_PI        6.283185307
`define RSG_BUF_EMPTY     2'h0
`define RSG_BUF_ONE       2'h1
`define RSG_BUF_FULL      2'h2
`define RSG_SYNC_F_HZ     200
`define RSG_BASE_HZ       60000
`define RSG_FMIN_HZ       20
`define RSG_FMAX_HZ       20000

`endif

// ### rsg_sine_gen.v
// rsg_sine_gen.v: divide-by-n sweep of a 256x8 sine table into a dac word stream
// assumes clk_i is the master clock; control inputs come from a processor on
// another clock and are synchronised here; zero_cross_i is an asynchronous pin
// div_n_i is read raw, qualified by the synchronised load edge: it must stand
// unchanged while div_load_i is high and a few cycles after
`timescale 1ns/1ps
`include "rsg_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module rsg_sine_gen #(
    parameter N_W    = `RSG_N_W,
    parameter DATA_W = `RSG_DATA_W
) (
    input  wire              clk_i,          // master clock
    input  wire              nrst_i,         // async reset, active low
    input  wire [N_W-1:0]    div_n_i,        // division value n
    input  wire              div_load_i,     // level: load n (rising edge acts)
    input  wire              polarity_i,     // 0: zero phase, 1: inverted
    input  wire              sync_en_i,      // line sync wanted (test below 200 Hz)
    input  wire              meas_done_i,    // level: measurement cycle completed
    input  wire              zero_cross_i,   // power-line zero crossing detector
    input  wire              dac_ready_i,    // dac accepts a word
    output wire              dac_valid_o,    // word available
    output wire [DATA_W-1:0] dac_data_o,     // word to dac
    output reg               cpu_clk_o,      // master clock divided by four
    output wire              sync_armed_o,   // waiting for zero crossing
    output wire              n_range_err_o   // loaded n outside 3..3000
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers: first stage read only by second stage
// prev flops turn the synchronised levels into one-cycle edge pulses
reg  [4:0] sy1_q;
reg  [4:0] sy2_q;
reg        load_prev_q;
reg        zc_prev_q;
reg        done_prev_q;

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        sy1_q       <= 5'h0;
        sy2_q       <= 5'h0;
        load_prev_q <= 1'b0;
        zc_prev_q   <= 1'b0;
        done_prev_q <= 1'b0;
    end else begin
        sy1_q       <= {div_load_i, polarity_i, sync_en_i, meas_done_i, zero_cross_i};
        sy2_q       <= sy1_q;
        load_prev_q <= sy2_q[4];
        zc_prev_q   <= sy2_q[0];
        done_prev_q <= sy2_q[1];
    end
end

wire load_s  = sy2_q[4];
wire pol_s   = sy2_q[3];
wire synce_s = sy2_q[2];
wire load_p  = load_s & ~load_prev_q;
wire zc_p    = sy2_q[0] & ~zc_prev_q;
wire done_p  = sy2_q[1] & ~done_prev_q;

////////////////////////////////////////////////////////////////////////////////
// processor clock divider
reg [`RSG_CPU_DIV_W-1:0] cpu_cnt_q;
// output is count bit one, one clock late: 50% duty, no glitch

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        cpu_cnt_q <= {`RSG_CPU_DIV_W{1'b0}};
        cpu_clk_o <= 1'b0;
    end else begin
        cpu_cnt_q <= cpu_cnt_q + 1'b1;
        cpu_clk_o <= cpu_cnt_q[`RSG_CPU_DIV_W-1];
    end
end

////////////////////////////////////////////////////////////////////////////////
// presettable divide-by-n; out-of-range n is clamped so the rate stays bounded
// counter reloads n-1 at zero, so one step every n clocks
// a load restarts the count so the new rate starts clean
function [N_W-1:0] rsg_clamp;
    input [N_W-1:0] n;
    begin
        if (n < `RSG_N_MIN)
            rsg_clamp = `RSG_N_MIN;
        else if (n > `RSG_N_MAX)
            rsg_clamp = `RSG_N_MAX;
        else
            rsg_clamp = n;
    end
endfunction

reg [N_W-1:0] n_q;
reg [N_W-1:0] div_cnt_q;
reg           range_err_q;
wire          stall;
wire          step = (div_cnt_q == {N_W{1'b0}}) & ~stall;

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        n_q         <= `RSG_N_RST;
        div_cnt_q   <= {N_W{1'b0}};
        range_err_q <= 1'b0;
    end else begin
        if (load_p) begin
            n_q         <= rsg_clamp(div_n_i);
            range_err_q <= (div_n_i != rsg_clamp(div_n_i));
            div_cnt_q   <= {N_W{1'b0}};
        end else if (!stall) begin
            if (div_cnt_q == {N_W{1'b0}})
                div_cnt_q <= n_q - 1'b1;
            else
                div_cnt_q <= div_cnt_q - 1'b1;
        end
    end
end
assign n_range_err_o = range_err_q;

////////////////////////////////////////////////////////////////////////////////
// address counter with line sync
reg [`RSG_ADDR_W-1:0] addr_q;
reg                   armed_q;

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        addr_q  <= `RSG_ADDR_ZERO;
        armed_q <= 1'b0;
    end else begin
        // crossing wins over a same-cycle step; a completion in the same
        // cycle re-arms, so the set is never lost
        if (armed_q && zc_p) begin
            addr_q  <= `RSG_ADDR_ZERO;
            armed_q <= done_p & synce_s;
        end else begin
            if (done_p && synce_s)
                armed_q <= 1'b1;
            if (step)
                addr_q <= addr_q + 1'b1;
        end
    end
end
assign sync_armed_o = armed_q;

////////////////////////////////////////////////////////////////////////////////
// 256x8 table: low half zero phase, high half inverted
reg [DATA_W-1:0] rom [0:`RSG_ROM_DEPTH-1];
integer          k;
integer          amp;
integer          lo_w;
integer          hi_w;

// filled once at start; amplitude truncates toward zero, words stay 1..255
initial begin
    for (k = 0; k < `RSG_TAB_ENTRIES; k = k + 1) begin
        amp  = $rtoi(`RSG_AMPL * $sin(`RSG_TWO_PI * k / `RSG_TAB_ENTRIES));
        lo_w = `RSG_MID + amp;
        hi_w = `RSG_MID - amp;
        rom[k]                    = lo_w[DATA_W-1:0];
        rom[k + `RSG_TAB_ENTRIES] = hi_w[DATA_W-1:0];
    end
end

wire [`RSG_ADDR_W:0] rom_addr = {pol_s, addr_q};

////////////////////////////////////////////////////////////////////////////////
// two-entry output buffer; stall holds the sweep rather than drop a word
// push side: valid is step, ready is ~stall; pop side: dac handshake
// head word stands on dac_data_o until the dac takes it
reg [DATA_W-1:0] buf0_q;
reg [DATA_W-1:0] buf1_q;
reg [1:0]        cnt_q;
wire             push = step;
wire             pop  = dac_ready_i & (cnt_q != `RSG_BUF_EMPTY);
assign stall = (cnt_q == `RSG_BUF_FULL);

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        buf0_q <= {DATA_W{1'b0}};
        buf1_q <= {DATA_W{1'b0}};
        cnt_q  <= `RSG_BUF_EMPTY;
    end else begin
        case ({push, pop})
            2'b10: begin
                if (cnt_q == `RSG_BUF_EMPTY)
                    buf0_q <= rom[rom_addr];
                else
                    buf1_q <= rom[rom_addr];
                cnt_q <= cnt_q + `RSG_BUF_ONE;
            end
            2'b01: begin
                buf0_q <= buf1_q;
                cnt_q  <= cnt_q - `RSG_BUF_ONE;
            end
            2'b11: begin
                if (cnt_q == `RSG_BUF_ONE)
                    buf0_q <= rom[rom_addr];
                else begin
                    buf0_q <= buf1_q;
                    buf1_q <= rom[rom_addr];
                end
            end
            default: begin
                cnt_q <= cnt_q;
            end
        endcase
    end
end

assign dac_valid_o = (cnt_q != `RSG_BUF_EMPTY);
assign dac_data_o  = buf0_q;

endmodule

// ### rsg_monitor.sv
// port checker for the sine table generator
// assumes bind to rsg_sine_gen, one clock domain
`timescale 1ns/1ps
`include "rsg_defines.vh"
module rsg_monitor (
    input wire        clk_i,        // clock
    input wire        nrst_i,       // reset
    input wire [11:0] div_n_i,      // n
    input wire        sync_en_i,    // sync on
    input wire        meas_done_i,  // done
    input wire        zero_cross_i, // crossing
    input wire        dac_ready_i,  // ready
    input wire        dac_valid_o,  // valid
    input wire [7:0]  dac_data_o,   // word
    input wire        cpu_clk_o,    // clk/4
    input wire        sync_armed_o, // armed
    input wire        n_range_err_o // clamped
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////
    chk_cpu_high: assert property ($rose(cpu_clk_o) |=> cpu_clk_o ##1 !cpu_clk_o)
        else $error("cpu clock high phase wrong");
    chk_cpu_low: assert property ($fell(cpu_clk_o) |=> !cpu_clk_o ##1 cpu_clk_o)
        else $error("cpu clock low phase wrong");
    chk_stall_hold: assert property (dac_valid_o && !dac_ready_i
        |=> dac_valid_o && $stable(dac_data_o)) else $error("stalled word lost");
    chk_word_nonzero: assert property (dac_valid_o |-> dac_data_o != 8'h00)
        else $error("word outside sine table");
    chk_err_set: assert property ($rose(n_range_err_o)
        |-> div_n_i < `RSG_N_MIN || div_n_i > `RSG_N_MAX) else $error("flag on legal n");
    chk_err_clear: assert property ($fell(n_range_err_o)
        |-> div_n_i >= `RSG_N_MIN && div_n_i <= `RSG_N_MAX) else $error("flag off bad n");
    chk_arm_cause: assert property ($rose(sync_armed_o)
        |-> sync_en_i && meas_done_i) else $error("armed without cause");
    chk_disarm_cause: assert property ($fell(sync_armed_o) |-> zero_cross_i)
        else $error("disarmed without crossing");
endmodule
bind rsg_sine_gen rsg_monitor i_rsg_monitor (.clk_i, .nrst_i, .div_n_i, .sync_en_i,
    .meas_done_i, .zero_cross_i, .dac_ready_i, .dac_valid_o, .dac_data_o, .cpu_clk_o,
    .sync_armed_o, .n_range_err_o);

// ### rsg_dac_sink.sv
// dac side model: takes words, stalls on request
// assumes the generator's clock
`timescale 1ns/1ps
module rsg_dac_sink (
    input  wire       clk_i,   // clock
    input  wire       nrst_i,  // reset
    input  wire       stall_i, // hold off
    input  wire       valid_i, // word present
    input  wire [7:0] data_i,  // word
    output wire       ready_o, // accepts
    output reg        took_o,  // took last cycle
    output reg  [7:0] word_o   // last word
);
    assign ready_o = !stall_i;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            took_o <= 1'b0;
            word_o <= 8'h00;
        end else begin
            took_o <= valid_i && ready_o;
            if (valid_i && ready_o) word_o <= data_i;
        end
    end
endmodule

// ### rsg_sine_gen_tb.sv
// bench: line sync, table sweep both regions, divider rates
// assumes rsg_sine_gen, rsg_dac_sink, bound checker
`timescale 1ns/1ps
`include "rsg_defines.vh"
module rsg_sine_gen_tb;
    reg         clk_i = 1'b0;
    reg         nrst_i = 1'b0;
    reg  [11:0] div_n_i = 12'h0003;
    reg         div_load_i = 1'b0;
    reg         polarity_i = 1'b0;
    reg         sync_en_i = 1'b0;
    reg         meas_done_i = 1'b0;
    reg         zero_cross_i = 1'b0;
    reg         stall = 1'b0;
    wire        dac_ready_i, dac_valid_o, cpu_clk_o, sync_armed_o, n_range_err_o, took;
    wire [7:0]  dac_data_o, word;
    integer     failures = 0;
    integer     samples_checked = 0;
    integer     i, p, c;
    reg  [11:0] nt [0:2];
    reg  [11:0] sp [0:2];
    always #25 clk_i = ~clk_i;
    rsg_sine_gen i_rsg_sine_gen (.clk_i, .nrst_i, .div_n_i, .div_load_i, .polarity_i,
        .sync_en_i, .meas_done_i, .zero_cross_i, .dac_ready_i, .dac_valid_o, .dac_data_o,
        .cpu_clk_o, .sync_armed_o, .n_range_err_o);
    rsg_dac_sink i_rsg_dac_sink (.clk_i, .nrst_i, .stall_i(stall), .valid_i(dac_valid_o),
        .data_i(dac_data_o), .ready_o(dac_ready_i), .took_o(took), .word_o(word));
    ////////////////////////////////////////
    task check(input [11:0] seen, input [11:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("failures %0d samples_checked %0d", failures, samples_checked);
            if (failures == 0 && samples_checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    // c ends as cycles since the previous take
    task get_word;
        begin
            c = 0;
            @(posedge clk_i);
            #1;
            while (took !== 1'b1 && c < 4000) begin
                @(posedge clk_i);
                #1;
                c = c + 1;
            end
            if (c == 4000) begin
                failures = failures + 1;
                test_done;
            end
            c = c + 1;
        end
    endtask
    task load(input [11:0] v);
        begin
            @(posedge clk_i) div_n_i <= v;
            @(posedge clk_i) div_load_i <= 1'b1;
            repeat (6) @(posedge clk_i);
            div_load_i <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask
    function [7:0] rom(input p, input integer a);
        integer f;
        begin
            // table amplitude truncates toward zero
            f = $rtoi(127.0 * $sin(`RSG_TWO_PI * a / 128.0));
            f = p ? 128 - f : 128 + f;
            rom = f[7:0];
        end
    endfunction
    ////////////////////////////////////////
    initial begin
        nt[0] = 12'h0002; sp[0] = 12'h0003;
        nt[1] = 12'h0BB9; sp[1] = 12'h0BB8;
        nt[2] = 12'h0005; sp[2] = 12'h0005;
        repeat (12) @(posedge clk_i);
        check(dac_valid_o, 0);
        nrst_i <= 1'b1;
        // frozen buffer lets the crossing land between two known words
        for (p = 0; p < 2; p = p + 1) begin
            @(posedge clk_i);
            polarity_i <= p[0];
            stall <= 1'b1;
            sync_en_i <= 1'b1;
            meas_done_i <= 1'b1;
            repeat (10) @(posedge clk_i);
            check(sync_armed_o, 1);
            meas_done_i <= 1'b0;
            zero_cross_i <= 1'b1;
            repeat (6) @(posedge clk_i);
            zero_cross_i <= 1'b0;
            check(sync_armed_o, 0);
            stall <= 1'b0;
            get_word;
            get_word;
            for (i = 0; i < 130; i = i + 1) begin
                get_word;
                check(word, rom(p[0], i % 128));
            end
        end
        for (i = 0; i < 3; i = i + 1) begin
            load(nt[i]);
            check(n_range_err_o, nt[i] < 3 || nt[i] > 3000);
            get_word;
            get_word;
            get_word;
            check(c, sp[i]);
        end
        test_done;
    end
endmodule
